// File: hdl/shcs_pkg.sv
// Package: offsets, field positions and reset values of the handler control and state block
package shcs_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0]  HCS_OFF      = 4'h0;
  localparam logic [3:0]  IRQ_STAT_OFF = 4'h4;
  localparam logic [3:0]  IRQ_MASK_OFF = 4'h8;
  // ==========================================================
  // Field positions of handler_control_state
  localparam int          PROT_EN_BIT    = 16;
  localparam int          SVC_PEND_BIT   = 15;
  localparam int          BUS_PEND_BIT   = 14;
  localparam int          PROT_PEND_BIT  = 13;
  localparam int          USAGE_PEND_BIT = 12;
  localparam int          TICK_ACT_BIT   = 11;
  localparam int          DEFER_ACT_BIT  = 10;
  localparam int          DEBUG_ACT_BIT  = 8;
  localparam int          SVC_ACT_BIT    = 7;
  localparam int          USAGE_ACT_BIT  = 3;
  localparam int          BUS_ACT_BIT    = 1;
  // Writable bits; all others read zero
  localparam logic [31:0] HCS_WMASK      = 32'h0001_fd8a;
  // ==========================================================
  // Reset values and interrupt layout
  localparam logic [31:0] HCS_RESET      = 32'h0000_0000;
  localparam int          IRQ_W          = 2;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam int          EV_ESC_BIT     = 0;
  localparam int          EV_REFUSE_BIT  = 1;
  // ==========================================================
  // Bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
endpackage : shcs_pkg

// File: hdl/shcs_regs.sv
// Handler control and state register with AXI4-Lite slave and event interrupt
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module shcs_regs (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core exception events, one-cycle pulses
  input  wire logic [3:0]  pend_set,
  input  wire logic [3:0]  pend_clr,
  input  wire logic [5:0]  act_set,
  input  wire logic [5:0]  act_clr,
  input  wire logic        prot_fault_req,
  // Flag state and fault routing
  output logic             prot_fault_enable,
  output logic [3:0]       pending,
  output logic [5:0]       active,
  output logic             prot_fault_take,
  output logic             hard_fault_take,
  output logic             irq
);
  // ==========================================================
  // Field mapping
  function automatic logic [31:0] pend_map(input logic [3:0] p);
    pend_map = 32'h0;
    pend_map[shcs_pkg::SVC_PEND_BIT]   = p[3];
    pend_map[shcs_pkg::BUS_PEND_BIT]   = p[2];
    pend_map[shcs_pkg::PROT_PEND_BIT]  = p[1];
    pend_map[shcs_pkg::USAGE_PEND_BIT] = p[0];
  endfunction : pend_map

  function automatic logic [31:0] act_map(input logic [5:0] a);
    act_map = 32'h0;
    act_map[shcs_pkg::TICK_ACT_BIT]  = a[5];
    act_map[shcs_pkg::DEFER_ACT_BIT] = a[4];
    act_map[shcs_pkg::DEBUG_ACT_BIT] = a[3];
    act_map[shcs_pkg::SVC_ACT_BIT]   = a[2];
    act_map[shcs_pkg::USAGE_ACT_BIT] = a[1];
    act_map[shcs_pkg::BUS_ACT_BIT]   = a[0];
  endfunction : act_map

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      strb_mask[i*8 +: 8] = {8{s[i]}};
    end
  endfunction : strb_mask

  // ==========================================================
  // State
  logic [31:0]              hcs;
  logic [shcs_pkg::IRQ_W-1:0] stat;
  logic [shcs_pkg::IRQ_W-1:0] mask;
  logic                     aw_hold;
  logic                     w_hold;
  logic [3:0]               awaddr_q;
  logic                     awpriv_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;

  // ==========================================================
  // Write channel decode; address and data may arrive in either order
  wire        aw_take = awvalid && awready;
  wire        w_take  = wvalid && wready;
  wire [3:0]  wa      = aw_hold ? awaddr_q : awaddr;
  wire        wpriv   = aw_hold ? awpriv_q : awprot[0];
  wire [31:0] wd_raw  = w_hold ? wdata_q : wdata;
  wire [31:0] wm      = strb_mask(w_hold ? wstrb_q : wstrb);
  wire        wr_fire = ce && (aw_hold || aw_take) && (w_hold || w_take) && !bvalid;
  wire        w_hit   = wa == shcs_pkg::HCS_OFF || wa == shcs_pkg::IRQ_STAT_OFF ||
                        wa == shcs_pkg::IRQ_MASK_OFF;
  wire        wr_ok   = wr_fire && wpriv && w_hit;
  wire        hcs_wr  = wr_ok && wa == shcs_pkg::HCS_OFF;
  wire [31:0] wd      = (wd_raw & wm) | (hcs & ~wm);
  wire        stat_wr = wr_ok && wa == shcs_pkg::IRQ_STAT_OFF;
  wire        mask_wr = wr_ok && wa == shcs_pkg::IRQ_MASK_OFF;

  assign awready = ce && !aw_hold && !bvalid;
  assign wready  = ce && !w_hold && !bvalid;

  // ==========================================================
  // Read channel decode
  wire        ar_take = arvalid && arready;
  wire        r_hit   = araddr == shcs_pkg::HCS_OFF || araddr == shcs_pkg::IRQ_STAT_OFF ||
                        araddr == shcs_pkg::IRQ_MASK_OFF;
  wire        rd_ok   = arprot[0] && r_hit;
  wire [31:0] rd_mux  = (araddr == shcs_pkg::HCS_OFF) ? hcs :
                        (araddr == shcs_pkg::IRQ_STAT_OFF) ? {30'h0, stat} :
                        {30'h0, mask};
  wire        refused = (wr_fire && !wpriv) || (ce && ar_take && !arprot[0]);

  assign arready = ce && !rvalid;

  // ==========================================================
  // Flag update: hardware set wins over a write and over a hardware clear
  wire        esc     = ce && prot_fault_req && !hcs[shcs_pkg::PROT_EN_BIT];
  wire        take    = ce && prot_fault_req && hcs[shcs_pkg::PROT_EN_BIT];
  wire [31:0] hw_set  = pend_map(pend_set | {2'h0, take, 1'b0}) | act_map(act_set);
  wire [31:0] hw_clr  = pend_map(pend_clr) | act_map(act_clr);
  wire [31:0] base    = hcs_wr ? wd : hcs;
  wire [31:0] next_hcs = ((base & ~hw_clr) | hw_set) & shcs_pkg::HCS_WMASK;
  wire [shcs_pkg::IRQ_W-1:0] ev = {refused, esc};
  wire [shcs_pkg::IRQ_W-1:0] next_stat =
    (stat & ~(stat_wr ? wd_raw[shcs_pkg::IRQ_W-1:0] & wm[shcs_pkg::IRQ_W-1:0] : 2'h0)) | ev;
  // Irq follows a new mask at once, not one cycle late
  wire [shcs_pkg::IRQ_W-1:0] next_mask = !mask_wr ? mask :
    (wd_raw[shcs_pkg::IRQ_W-1:0] & wm[shcs_pkg::IRQ_W-1:0]) |
    (mask & ~wm[shcs_pkg::IRQ_W-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcs <= shcs_pkg::HCS_RESET;
      stat <= shcs_pkg::IRQ_RESET;
      mask <= shcs_pkg::IRQ_RESET;
    end else if (ce) begin
      hcs <= next_hcs;
      stat <= next_stat;
      mask <= next_mask;
    end
  end

  // ==========================================================
  // Bus handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      awaddr_q <= 4'h0;
      awpriv_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= shcs_pkg::RESP_OKAY;
    end else if (ce) begin
      aw_hold <= !wr_fire && (aw_hold || aw_take);
      w_hold <= !wr_fire && (w_hold || w_take);
      if (aw_take) begin
        awaddr_q <= awaddr;
        awpriv_q <= awprot[0];
      end
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= !w_hit ? shcs_pkg::RESP_DECERR :
                 !wpriv ? shcs_pkg::RESP_SLVERR : shcs_pkg::RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= shcs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata <= rd_ok ? rd_mux : 32'h0;
        rresp <= !r_hit ? shcs_pkg::RESP_DECERR :
                 !arprot[0] ? shcs_pkg::RESP_SLVERR : shcs_pkg::RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Fault routing pulses; registered so the core sees clean timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_fault_take <= 1'b0;
      hard_fault_take <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      prot_fault_take <= take;
      hard_fault_take <= esc;
      irq <= |(next_stat & next_mask);
    end
  end

  assign prot_fault_enable = hcs[shcs_pkg::PROT_EN_BIT];
  assign pending = {hcs[shcs_pkg::SVC_PEND_BIT], hcs[shcs_pkg::BUS_PEND_BIT],
                    hcs[shcs_pkg::PROT_PEND_BIT], hcs[shcs_pkg::USAGE_PEND_BIT]};
  assign active  = {hcs[shcs_pkg::TICK_ACT_BIT], hcs[shcs_pkg::DEFER_ACT_BIT],
                    hcs[shcs_pkg::DEBUG_ACT_BIT], hcs[shcs_pkg::SVC_ACT_BIT],
                    hcs[shcs_pkg::USAGE_ACT_BIT], hcs[shcs_pkg::BUS_ACT_BIT]};

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_clear;
    disable iff (1'b0) !aresetn && ce |=> pending == 4'h0 && active == 6'h0 && !prot_fault_enable;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("flags not cleared");
  property p_enable_take;
    ce && prot_fault_req && prot_fault_enable |=> prot_fault_take && !hard_fault_take;
  endproperty
  a_enable_take: assert property (p_enable_take) else $error("enabled fault lost");
  property p_escalate;
    ce && prot_fault_req && !prot_fault_enable |=> hard_fault_take && !prot_fault_take;
  endproperty
  a_escalate: assert property (p_escalate) else $error("no escalation");
  property p_svc_pend;
    hcs_wr && !pend_set[3] && !pend_clr[3] |=> pending[3] == $past(wd[15]);
  endproperty
  a_svc_pend: assert property (p_svc_pend) else $error("svc pending write");
  property p_bus_pend;
    hcs_wr && !pend_set[2] && !pend_clr[2] |=> pending[2] == $past(wd[14]);
  endproperty
  a_bus_pend: assert property (p_bus_pend) else $error("bus pending write");
  property p_usage_pend;
    hcs_wr && !pend_set[0] && !pend_clr[0] |=> pending[0] == $past(wd[12]);
  endproperty
  a_usage_pend: assert property (p_usage_pend) else $error("usage pending write");
  property p_tick_act;
    hcs_wr && !act_set[5] && !act_clr[5] |=> active[5] == $past(wd[11]);
  endproperty
  a_tick_act: assert property (p_tick_act) else $error("tick active write");
  property p_bus_act;
    hcs_wr && !act_set[0] && !act_clr[0] |=> active[0] == $past(wd[1]);
  endproperty
  a_bus_act: assert property (p_bus_act) else $error("bus active write");
  property p_defer_act;
    hcs_wr && !act_set[4] && !act_clr[4] |=> active[4] == $past(wd[10]);
  endproperty
  a_defer_act: assert property (p_defer_act) else $error("deferred active write");
  property p_usage_act;
    hcs_wr && !act_set[1] && !act_clr[1] |=> active[1] == $past(wd[3]);
  endproperty
  a_usage_act: assert property (p_usage_act) else $error("usage active write");
  property p_set_wins;
    ce && act_set[2] |=> active[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");
  property p_reserved;
    $rose(rvalid) && rresp == shcs_pkg::RESP_OKAY && $past(araddr) == shcs_pkg::HCS_OFF |->
      (rdata & ~shcs_pkg::HCS_WMASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_unpriv;
    wr_fire && !wpriv && hw_set == 32'h0 && hw_clr == 32'h0 |=>
      $stable(hcs) && bvalid && bresp == shcs_pkg::RESP_SLVERR;
  endproperty
  a_unpriv: assert property (p_unpriv) else $error("unprivileged write took");

  property p_cov_write;
    hcs_wr;
  endproperty
  c_cov_write: cover property (p_cov_write);
  property p_cov_esc;
    esc ##1 irq;
  endproperty
  c_cov_esc: cover property (p_cov_esc);
  property p_cov_refuse;
    refused;
  endproperty
  c_cov_refuse: cover property (p_cov_refuse);
  property p_cov_take;
    prot_fault_take;
  endproperty
  c_cov_take: cover property (p_cov_take);
  property p_cov_irq;
    $rose(irq);
  endproperty
  c_cov_irq: cover property (p_cov_irq);
endmodule : shcs_regs

// File: dv/tb_top.sv
// Testbench: handler control and state block against an integer reference
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, prot_fault_req;
  logic [3:0]  awaddr, araddr, wstrb, pend_set, pend_clr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, v, hm, sv;
  logic [5:0]  act_set, act_clr;
  logic [1:0]  r, sm, mm;
  wire logic   awready, wready, bvalid, arready, rvalid, prot_fault_enable;
  wire logic   prot_fault_take, hard_fault_take, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  pending;
  wire logic [5:0]  active;
  integer      n_errors = 0, n_tests = 0, seed = 19875, cyc = 0, i;
  shcs_regs dut (.aclk, .aresetn, .ce, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pend_set, .pend_clr, .act_set, .act_clr, .prot_fault_req,
    .prot_fault_enable, .pending, .active, .prot_fault_take, .hard_fault_take, .irq);
  // ==========================================================
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("counts: tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge aclk);
    awaddr  <= a;
    awprot  <= p;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [2:0] p);
    @(posedge aclk);
    araddr  <= a;
    arprot  <= p;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic hw(input logic [31:0] d);
    wr(shcs_pkg::HCS_OFF, d, 3'h1);
    chk("bresp", shcs_pkg::RESP_OKAY, r);
    hm = d & shcs_pkg::HCS_WMASK;
  endtask : hw
  task automatic hr();
    rd(shcs_pkg::HCS_OFF, 3'h1);
    chk("hcs", hm, v);
    chk("pending", hm[15:12], pending);
    chk("enable", hm[16], prot_fault_enable);
    chk("active", {hm[11], hm[10], hm[8], hm[7], hm[3], hm[1]}, active);
  endtask : hr
  task automatic iq();
    repeat (3) @(posedge aclk);
    #1;
    chk("irq", |(sm & mm), irq);
    rd(shcs_pkg::IRQ_STAT_OFF, 3'h1);
    chk("status", sm, v);
  endtask : iq
  // Hardware set wins over clear, as the core sees it
  task automatic ev(input logic [31:0] x);
    logic [3:0] p;
    logic [5:0] a;
    @(posedge aclk);
    pend_set       <= x[3:0];
    pend_clr       <= x[7:4];
    act_set        <= x[13:8];
    act_clr        <= x[19:14];
    prot_fault_req <= x[20];
    @(posedge aclk);
    pend_set       <= 4'h0;
    pend_clr       <= 4'h0;
    act_set        <= 6'h0;
    act_clr        <= 6'h0;
    prot_fault_req <= 1'b0;
    #1;
    chk("hard_take", x[20] & ~hm[16], hard_fault_take);
    chk("prot_take", x[20] & hm[16], prot_fault_take);
    p = (hm[15:12] & ~x[7:4]) | x[3:0];
    a = ({hm[11], hm[10], hm[8], hm[7], hm[3], hm[1]} & ~x[19:14]) | x[13:8];
    if (x[20] && hm[16]) p[1] = 1'b1;
    if (x[20] && !hm[16]) sm[0] = 1'b1;
    hm[15:12] = p;
    {hm[11], hm[10], hm[8], hm[7], hm[3], hm[1]} = a;
  endtask : ev
  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, prot_fault_req} = 7'h0;
    {awaddr, araddr, pend_set, pend_clr, awprot, arprot, act_set, act_clr} = 34'h0;
    ce = 1'b1;
    wstrb = 4'hf;
    wdata = 32'h0;
    {hm, sm, mm} = 36'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    hr();
    iq();
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      hw($random(seed));
      hr();
    end
    hw(32'hffff_ffff);
    hr();
    $display("test register done");
    // Byte lanes merge; read-modify-write keeps reserved bits; saved active state put back
    rd(shcs_pkg::HCS_OFF, 3'h1);
    sv = v;
    wstrb <= 4'h2;
    wr(shcs_pkg::HCS_OFF, ~sv, 3'h1);
    wstrb <= 4'hf;
    chk("bresp", shcs_pkg::RESP_OKAY, r);
    hm = ((~sv & 32'h0000_ff00) | (hm & 32'hffff_00ff)) & shcs_pkg::HCS_WMASK;
    hr();
    hw(v ^ 32'h0001_0000);
    hr();
    hw(sv);
    hr();
    $display("test merge done");
    // Refused accesses must leave the register alone
    wr(shcs_pkg::HCS_OFF, 32'h0, 3'h0);
    chk("bresp", shcs_pkg::RESP_SLVERR, r);
    rd(shcs_pkg::HCS_OFF, 3'h0);
    chk("rresp", shcs_pkg::RESP_SLVERR, r);
    chk("rdata", 32'h0, v);
    sm[1] = 1'b1;
    hr();
    wr(4'hc, 32'hffff_ffff, 3'h1);
    chk("bresp", shcs_pkg::RESP_DECERR, r);
    rd(4'hc, 3'h1);
    chk("rresp", shcs_pkg::RESP_DECERR, r);
    iq();
    $display("test refusal done");
    mm = 2'h2;
    wr(shcs_pkg::IRQ_MASK_OFF, 32'h2, 3'h1);
    iq();
    wr(shcs_pkg::IRQ_STAT_OFF, 32'h2, 3'h1);
    sm = 2'h0;
    iq();
    mm = 2'h1;
    wr(shcs_pkg::IRQ_MASK_OFF, 32'h1, 3'h1);
    $display("test interrupt done");
    for (i = 0; i < 24; i++) begin
      if (i % 6 == 0) hw($random(seed));
      ev($random(seed));
      hr();
      iq();
      wr(shcs_pkg::IRQ_STAT_OFF, {30'h0, sm}, 3'h1);
      sm = 2'h0;
    end
    iq();
    $display("test events done");
    // Frozen clock enable: core pulses in that cycle must leave no trace
    @(posedge aclk);
    ce             <= 1'b0;
    pend_set       <= 4'hf;
    act_set        <= 6'h3f;
    prot_fault_req <= 1'b1;
    @(posedge aclk);
    ce             <= 1'b1;
    pend_set       <= 4'h0;
    act_set        <= 6'h0;
    prot_fault_req <= 1'b0;
    #1;
    chk("hard_take", 1'b0, hard_fault_take);
    chk("prot_take", 1'b0, prot_fault_take);
    hr();
    $display("test freeze done");
    // Reset in mid-run clears flags, status and mask alike
    wr(shcs_pkg::HCS_OFF, 32'h0, 3'h0);
    chk("bresp", shcs_pkg::RESP_SLVERR, r);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    {hm, sm, mm} = 36'h0;
    hr();
    iq();
    $display("test second reset done");
    summarize();
  end
endmodule : tb_top
